/* hw/molim_pkg.sv */
package molim_pkg;
   localparam int CUR_W = 16;
   localparam int ACC_W = 32;

   // register byte offsets
   localparam logic [7:0] ADDR_SUBMODE = 8'h00;
   localparam logic [7:0] ADDR_MAXCUR = 8'h04;
   localparam logic [7:0] ADDR_RATED = 8'h08;
   localparam logic [7:0] ADDR_PEAK = 8'h0c;
   localparam logic [7:0] ADDR_DURATION = 8'h10;
   localparam logic [7:0] ADDR_THRESHOLD = 8'h14;
   localparam logic [7:0] ADDR_ACCUM = 8'h18;
   localparam logic [7:0] ADDR_LIMIT = 8'h1c;
   localparam logic [7:0] ADDR_STATUS = 8'h20;

   localparam int CLOSED_LOOP_BIT = 0;

   // values after reset
   localparam logic [CUR_W-1:0] RST_SUBMODE = 16'h0000;
   localparam logic [CUR_W-1:0] RST_MAXCUR = 16'h0000;
   localparam logic [CUR_W-1:0] RST_RATED = 16'h0000;
   localparam logic [CUR_W-1:0] RST_PEAK = 16'h0000;
   localparam logic [CUR_W-1:0] RST_DURATION = 16'h0000;

   // scale divisors: tenths of a percent, and milliseconds per second
   localparam logic [ACC_W-1:0] PERMILLE_DIV = 32'h0000_03e8;
   localparam logic [ACC_W-1:0] MS_PER_S = 32'h0000_03e8;

   localparam logic [0:0] STATUS_OFF = 1'h0;
   localparam logic [0:0] STATUS_ON = 1'h1;

   typedef struct packed {
      logic [CUR_W-1:0] submode;
      logic [CUR_W-1:0] maxMotorCurrent;
      logic [CUR_W-1:0] ratedCurrent;
      logic [CUR_W-1:0] peakSetting;
      logic [CUR_W-1:0] peakDurationSetting;
   } molim_cfg_type;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_PEAK = 5'b00010,
      ST_INC = 5'b00100,
      ST_THR = 5'b01000,
      ST_ACC = 5'b10000
   } molim_state_type;
endpackage

/* hw/molim_divider.sv */
`timescale 1ns/1ps
// unsigned restoring divider, one quotient bit per cycle
module molim_divider #(
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [W-1:0] dividend,
   input wire logic [W-1:0] divisor,
   output logic [W-1:0] quotient_q,
   output logic done_q
);
   localparam int CNT_W = $clog2(W + 1);

   initial begin
      if (W < 2) $error("divider width too small");
   end

   logic [W-1:0] rem_q;
   logic [W-1:0] div_q;
   logic [CNT_W-1:0] count_q;
   logic busy_q;
   logic [W:0] trial;

   always_comb begin
      trial = {rem_q, quotient_q[W-1]} - {1'b0, div_q};
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rem_q <= '0;
         div_q <= '0;
         quotient_q <= '0;
         count_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (start) begin
            rem_q <= '0;
            div_q <= divisor;
            quotient_q <= dividend;
            count_q <= CNT_W'(W);
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (trial[W]) begin
               rem_q <= {rem_q[W-2:0], quotient_q[W-1]};
               quotient_q <= {quotient_q[W-2:0], 1'b0};
            end else begin
               rem_q <= trial[W-1:0];
               quotient_q <= {quotient_q[W-2:0], 1'b1};
            end
            count_q <= count_q - 1'b1;
            if (count_q == CNT_W'(1)) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end
endmodule

/* hw/molim_top.sv */
`timescale 1ns/1ps
// overload current limiter: apb registers, load integration, limit selection
module molim_top #(
   parameter int CUR_W = molim_pkg::CUR_W,
   parameter int ACC_W = molim_pkg::ACC_W
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CUR_W-1:0] measuredCurrent,
   input wire logic sampleValid,
   output logic [CUR_W-1:0] appliedCurrentLimit,
   output logic protectionActive
);
   initial begin
      if (CUR_W != 16) begin
         $error("current width must be 16");
      end
      if (ACC_W != 32) begin
         $error("figure width must be 32");
      end
      if (ACC_W < 2 * CUR_W) begin
         $error("figure too narrow for a squared current");
      end
   end

   molim_pkg::molim_cfg_type cfg_q;
   molim_pkg::molim_state_type state_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [CUR_W-1:0] limit_q;
   logic active_q;
   logic [CUR_W-1:0] peakRaw_q;
   logic [CUR_W-1:0] peakClamp_q;
   logic [CUR_W-1:0] sample_q;
   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] thrMas_q;
   logic [ACC_W-1:0] accMas_q;
   logic [ACC_W-1:0] divA_q;
   logic [ACC_W-1:0] divB_q;
   logic divStart_q;
   logic [ACC_W-1:0] divQ;
   logic divDone;

   logic [CUR_W-1:0] peakRaw;
   logic [CUR_W-1:0] peakClamp;
   logic [CUR_W-1:0] delta;
   logic [CUR_W-1:0] excess;
   logic [ACC_W-1:0] loadLimit;
   logic [ACC_W-1:0] accNew;
   logic [ACC_W:0] accSum;
   logic activeNow;
   logic wrEn;
   logic rdMapped;
   logic wrMapped;
   logic [31:0] readWord;

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign appliedCurrentLimit = limit_q;
   assign protectionActive = active_q;

   // peak in mA from the divider result, saturated to the current width
   always_comb begin
      if (state_q == molim_pkg::ST_PEAK) begin
         peakRaw = (divQ[ACC_W-1:CUR_W] != '0) ? '1 : divQ[CUR_W-1:0];
      end else begin
         peakRaw = peakRaw_q;
      end
   end

   // peak held under the motor ceiling, and its margin over rated
   always_comb begin
      peakClamp = (peakRaw > cfg_q.maxMotorCurrent) ? cfg_q.maxMotorCurrent : peakRaw;
      delta = (peakClamp > cfg_q.ratedCurrent) ? peakClamp - cfg_q.ratedCurrent : '0;
   end

   // distance of the sample from rated, on either side
   always_comb begin
      excess = (sample_q > cfg_q.ratedCurrent) ? sample_q - cfg_q.ratedCurrent
                                               : cfg_q.ratedCurrent - sample_q;
   end

   // load limit in mA*ms
   always_comb begin
      loadLimit = ACC_W'(delta * cfg_q.peakDurationSetting);
   end

   // activation from the stored configuration
   always_comb begin
      activeNow = cfg_q.submode[molim_pkg::CLOSED_LOOP_BIT]
                  && (peakRaw_q > cfg_q.ratedCurrent)
                  && (cfg_q.peakDurationSetting != '0);
   end

   // figure update from the increment in divQ
   always_comb begin
      accSum = {1'b0, acc_q} + {1'b0, divQ};
      if (!activeNow) begin
         accNew = '0;
      end else if (sample_q > cfg_q.ratedCurrent) begin
         accNew = accSum[ACC_W] ? '1 : accSum[ACC_W-1:0];
      end else begin
         accNew = (acc_q > divQ) ? acc_q - divQ : '0;
      end
   end

   // apb decode
   always_comb begin
      wrEn = psel && penable && pready_q && pwrite;
      rdMapped = (paddr <= molim_pkg::ADDR_STATUS) && (paddr[1:0] == 2'h0);
      wrMapped = (paddr <= molim_pkg::ADDR_DURATION) && (paddr[1:0] == 2'h0);
   end

   // ready only in the access cycle, so every transfer has zero wait states
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= psel && !penable;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pslverr_q <= 1'b0;
      end else begin
         pslverr_q <= psel && !penable && (pwrite ? !wrMapped : !rdMapped);
      end
   end

   // read word for the addressed register, taken into prdata in the setup cycle
   always_comb begin
      unique case (paddr)
         molim_pkg::ADDR_SUBMODE: readWord = {16'h0000, cfg_q.submode};
         molim_pkg::ADDR_MAXCUR: readWord = {16'h0000, cfg_q.maxMotorCurrent};
         molim_pkg::ADDR_RATED: readWord = {16'h0000, cfg_q.ratedCurrent};
         molim_pkg::ADDR_PEAK: readWord = {16'h0000, cfg_q.peakSetting};
         molim_pkg::ADDR_DURATION: readWord = {16'h0000, cfg_q.peakDurationSetting};
         molim_pkg::ADDR_THRESHOLD: readWord = thrMas_q;
         molim_pkg::ADDR_ACCUM: readWord = accMas_q;
         molim_pkg::ADDR_LIMIT: readWord = {16'h0000, limit_q};
         molim_pkg::ADDR_STATUS: readWord = {31'h0000_0000, active_q};
         default: readWord = '0;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prdata_q <= '0;
      end else if (psel && !penable) begin
         prdata_q <= readWord;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_q.submode <= molim_pkg::RST_SUBMODE;
         cfg_q.maxMotorCurrent <= molim_pkg::RST_MAXCUR;
         cfg_q.ratedCurrent <= molim_pkg::RST_RATED;
         cfg_q.peakSetting <= molim_pkg::RST_PEAK;
         cfg_q.peakDurationSetting <= molim_pkg::RST_DURATION;
      end else if (wrEn) begin
         unique case (paddr)
            molim_pkg::ADDR_SUBMODE: cfg_q.submode <= pwdata[CUR_W-1:0];
            molim_pkg::ADDR_MAXCUR: cfg_q.maxMotorCurrent <= pwdata[CUR_W-1:0];
            molim_pkg::ADDR_RATED: cfg_q.ratedCurrent <= pwdata[CUR_W-1:0];
            molim_pkg::ADDR_PEAK: cfg_q.peakSetting <= pwdata[CUR_W-1:0];
            molim_pkg::ADDR_DURATION: cfg_q.peakDurationSetting <= pwdata[CUR_W-1:0];
            default: cfg_q.submode <= cfg_q.submode;
         endcase
      end
   end

   // one pass per control cycle: peak, increment, threshold, figure readout
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= molim_pkg::ST_IDLE;
         divStart_q <= 1'b0;
         divA_q <= '0;
         divB_q <= '0;
         sample_q <= '0;
      end else begin
         divStart_q <= 1'b0;
         unique case (state_q)
            // a sample that arrives during a pass is not taken
            molim_pkg::ST_IDLE: begin
               if (sampleValid) begin
                  sample_q <= measuredCurrent;
                  divA_q <= ACC_W'(cfg_q.ratedCurrent * cfg_q.peakSetting);
                  divB_q <= molim_pkg::PERMILLE_DIV;
                  divStart_q <= 1'b1;
                  state_q <= molim_pkg::ST_PEAK;
               end
            end
            molim_pkg::ST_PEAK: begin
               if (divDone) begin
                  // squared excess normalised so a steady peak adds delta per cycle
                  divA_q <= ACC_W'(excess * excess);
                  divB_q <= (delta == '0) ? ACC_W'(1) : ACC_W'(delta);
                  divStart_q <= 1'b1;
                  state_q <= molim_pkg::ST_INC;
               end
            end
            molim_pkg::ST_INC: begin
               if (divDone) begin
                  divA_q <= loadLimit;
                  divB_q <= molim_pkg::MS_PER_S;
                  divStart_q <= 1'b1;
                  state_q <= molim_pkg::ST_THR;
               end
            end
            molim_pkg::ST_THR: begin
               if (divDone) begin
                  divA_q <= acc_q;
                  divB_q <= molim_pkg::MS_PER_S;
                  divStart_q <= 1'b1;
                  state_q <= molim_pkg::ST_ACC;
               end
            end
            molim_pkg::ST_ACC: begin
               if (divDone) begin
                  state_q <= molim_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         peakRaw_q <= '0;
         peakClamp_q <= '0;
      end else if (state_q == molim_pkg::ST_PEAK && divDone) begin
         peakRaw_q <= peakRaw;
         peakClamp_q <= peakClamp;
      end
   end

   // figure is cleared whenever protection is off
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         acc_q <= '0;
      end else if (state_q == molim_pkg::ST_INC && divDone) begin
         acc_q <= accNew;
      end else if (!activeNow) begin
         acc_q <= '0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         thrMas_q <= '0;
         accMas_q <= '0;
      end else begin
         if (state_q == molim_pkg::ST_THR && divDone) begin
            thrMas_q <= divQ;
         end
         if (state_q == molim_pkg::ST_ACC && divDone) begin
            accMas_q <= divQ;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         active_q <= molim_pkg::STATUS_OFF;
      end else begin
         active_q <= activeNow ? molim_pkg::STATUS_ON : molim_pkg::STATUS_OFF;
      end
   end

   // limit drops to rated in the same cycle the figure reaches the limit
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         limit_q <= '0;
      end else if (state_q == molim_pkg::ST_INC && divDone && activeNow) begin
         limit_q <= (accNew >= loadLimit) ? cfg_q.ratedCurrent : peakClamp_q;
      end else if (!activeNow) begin
         limit_q <= peakClamp_q;
      end
   end

   molim_divider #(
      .W(ACC_W)
   ) u_div (
      .clk(clk),
      .reset(reset),
      .start(divStart_q),
      .dividend(divA_q),
      .divisor(divB_q),
      .quotient_q(divQ),
      .done_q(divDone)
   );
endmodule

/* verif/molim_top_monitor.sv */
`timescale 1ns/1ps
module molim_top_monitor #(
   parameter int CUR_W = 16,
   parameter int ACC_W = 32
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [CUR_W-1:0] measuredCurrent,
   input wire logic sampleValid,
   input wire logic [CUR_W-1:0] appliedCurrentLimit,
   input wire logic protectionActive
);
   logic acc;
   logic [7:0] quietCnt_q;
   assign acc = psel && penable;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // cycles since the last cause that may move the limit
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         quietCnt_q <= 8'h00;
      end else if (sampleValid || (acc && pwrite)) begin
         quietCnt_q <= 8'h00;
      end else if (quietCnt_q != 8'hff) begin
         quietCnt_q <= quietCnt_q + 8'h01;
      end
   end
   a_ready_access: assert property ((psel && !penable) ##1 acc |-> pready)
      else $error("no ready in access cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_quiet_idle: assert property (!acc |-> !pready && !pslverr)
      else $error("ready or error outside access");
   a_ro_refused: assert property (acc && pwrite && paddr inside {8'h14, 8'h18, 8'h1c, 8'h20}
      |-> pslverr)
      else $error("write to read-only value not refused");
   a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   a_err_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_status_read: assert property (acc && !pwrite && paddr == 8'h20
      |-> prdata == {31'h0, $past(protectionActive)})
      else $error("status read differs from port");
   a_limit_read: assert property (acc && !pwrite && paddr == 8'h1c
      |-> prdata[15:0] == $past(appliedCurrentLimit))
      else $error("limit read differs from port");
   a_limit_cause: assert property ($changed(appliedCurrentLimit) |-> quietCnt_q < 8'd100)
      else $error("limit moved without sample or write");
endmodule
bind molim_top molim_top_monitor #(.CUR_W(CUR_W), .ACC_W(ACC_W)) molim_top_monitor_i (
   .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .measuredCurrent(measuredCurrent), .sampleValid(sampleValid),
   .appliedCurrentLimit(appliedCurrentLimit), .protectionActive(protectionActive));

/* verif/molim_current_loop.sv */
`timescale 1ns/1ps
// current loop: follows demand but never above the applied limit, one sample per period
module molim_current_loop #(
   parameter int PERIOD = 200
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] demand,
   input wire logic [15:0] limit,
   output logic [15:0] measuredCurrent,
   output logic sampleValid
);
   logic [15:0] count_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count_q <= 16'h0000;
         sampleValid <= 1'b0;
         measuredCurrent <= 16'h0000;
      end else begin
         count_q <= (count_q == 16'(PERIOD - 1)) ? 16'h0000 : count_q + 16'h0001;
         sampleValid <= count_q == 16'(PERIOD - 1);
         if (count_q == 16'(PERIOD - 1)) begin
            measuredCurrent <= (demand < limit) ? demand : limit;
         end
      end
   end
endmodule

/* verif/molim_top_test.sv */
`timescale 1ns/1ps
module molim_top_test;
   typedef struct packed {logic [31:0] data; logic err;} molim_note_type;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, sampleValid, protectionActive;
   logic [15:0] measuredCurrent, appliedCurrentLimit;
   logic [15:0] demand = 16'h0000;
   int fails = 0;
   int compares = 0;
   int cycles = 0;
   molim_note_type notes[$];
   always #5 clk = ~clk;
   molim_top molim_top_i (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .measuredCurrent(measuredCurrent), .sampleValid(sampleValid),
      .appliedCurrentLimit(appliedCurrentLimit), .protectionActive(protectionActive));
   molim_current_loop molim_current_loop_i (.clk(clk), .reset(reset), .demand(demand),
      .limit(appliedCurrentLimit), .measuredCurrent(measuredCurrent),
      .sampleValid(sampleValid));
   task automatic cmp_bus(logic [31:0] got, logic [31:0] exp, logic ge, logic ee);
      compares++;
      if (got !== exp || ge !== ee) begin
         fails++;
         $display("unexpected at %0t: data %h err %b, want %h err %b", $time, got, ge, exp, ee);
      end
   endtask
   task automatic cmp_port(logic [15:0] got, logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: port %h, want %h", $time, got, exp);
      end
   endtask
   // the answer is judged where it appears, against the oldest note
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         if (notes.size() == 0) begin
            fails++;
            $display("unexpected at %0t: answer with no request", $time);
         end else begin
            cmp_bus(pwrite ? notes[0].data : prdata, notes[0].data, pslverr, notes[0].err);
            notes.delete(0);
         end
      end
   end
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic e);
      notes.push_back('{d, e});
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= w ? d : $urandom();
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] d);
      apb(1'b0, a, d, 1'b0);
   endtask
   task automatic wait_samples(int n);
      @(posedge clk);
      repeat (n) @(posedge sampleValid);
      repeat (150) @(posedge clk);
   endtask
   task automatic endt(string s);
      $display("test %0s done", s);
   endtask
   task automatic report_and_stop;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         fails++;
         $display("unexpected at %0t: run too long", $time);
         report_and_stop();
      end
   end
   initial begin
      void'($urandom(32'h8af8));
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'h0);
      apb(1'b0, 8'h24, 32'h0, 1'b1);
      apb(1'b1, 8'h18, 32'h5, 1'b1);
      endt("reset");
      demand <= 16'($urandom_range(999));
      wr(8'h08, 32'h3e8);
      wr(8'h0c, 32'h5dc);
      wr(8'h04, 32'h578);
      wr(8'h10, 32'h64);
      wait_samples(2);
      rd(8'h20, 32'h0);
      rd(8'h18, 32'h0);
      rd(8'h1c, 32'h578);
      cmp_port({15'h0, protectionActive}, 16'h0);
      endt("inactive");
      wr(8'h00, 32'h1);
      wr(8'h10, 32'h0);
      rd(8'h20, 32'h0);
      wr(8'h10, 32'h64);
      rd(8'h20, 32'h1);
      wr(8'h04, 32'h7d0);
      wait_samples(1);
      rd(8'h14, 32'h32);
      rd(8'h1c, 32'h5dc);
      endt("active");
      demand <= 16'h5dc;
      wait_samples(99);
      rd(8'h1c, 32'h5dc);
      rd(8'h18, 32'h31);
      wait_samples(1);
      rd(8'h1c, 32'h3e8);
      rd(8'h18, 32'h32);
      cmp_port(appliedCurrentLimit, 16'h3e8);
      demand <= 16'h0000;
      wait_samples(1);
      rd(8'h1c, 32'h5dc);
      rd(8'h18, 32'h30);
      endt("overload");
      report_and_stop();
   end
endmodule
